// ---- inc/bcef_consts.svh ----
`ifndef BCEF_CONSTS_SVH
`define BCEF_CONSTS_SVH

// Register offsets on the host register port
`define BCEF_ERR_FLAGS_OFS     8'h00
`define BCEF_STAT_FLAGS_OFS    8'h04

// Reset values and implemented-bit masks
`define BCEF_ERR_FLAGS_RST     32'h0000_0000
`define BCEF_STAT_FLAGS_RST    32'h0000_0000
`define BCEF_ERR_FLAGS_MASK    32'h0707_0fff
`define BCEF_STAT_FLAGS_MASK   32'h0303_8c00

// Error event flag bit positions
`define BCEF_E_SLOT_OVR_B      26
`define BCEF_E_TX_VIOL_B       25
`define BCEF_E_CH_ERR_B        24
`define BCEF_E_SLOT_OVR_A      18
`define BCEF_E_TX_VIOL_A       17
`define BCEF_E_CH_ERR_A        16
`define BCEF_E_HANDLER         11
`define BCEF_E_BAD_OB          10
`define BCEF_E_BAD_IB          9
`define BCEF_E_EMPTY_Q         8
`define BCEF_E_RXQ_OVR         7
`define BCEF_E_PARITY          6
`define BCEF_E_CMD_LOCK        5
`define BCEF_E_CLK_CORR        4
`define BCEF_E_SYNC_OVF        3
`define BCEF_E_SYNC_UNF        2
`define BCEF_E_CMD_REJ         1
`define BCEF_E_MODE_CHG        0

// Status event flag bit positions
`define BCEF_S_TEST_SYM_B      25
`define BCEF_S_WAKE_B          24
`define BCEF_S_TEST_SYM_A      17
`define BCEF_S_WAKE_A          16
`define BCEF_S_DYN_SEG         15
`define BCEF_S_OUT_DONE        11
`define BCEF_S_IN_DONE         10

// Host command codes
`define BCEF_CMD_NONE          4'h0
`define BCEF_CMD_CONFIG        4'h1
`define BCEF_CMD_READY         4'h2
`define BCEF_CMD_WAKEUP        4'h3
`define BCEF_CMD_RUN           4'h4
`define BCEF_CMD_HALT          4'h6
`define BCEF_CMD_FREEZE        4'h7

// Security field values and sync frame minimums
`define BCEF_SEC_STATIC_LOCK   2'h1
`define BCEF_MIN_SYNC_SYNCNODE 5'h01
`define BCEF_MIN_SYNC_OTHER    5'h02

`endif

// ---- inc/bcef_pkg.sv ----
package bcef_pkg;

  // Protocol state machine states, as reported by the protocol engine
  typedef enum logic [3:0] {
    PS_DEFAULT_CONFIG,
    PS_CONFIG,
    PS_READY,
    PS_WAKEUP,
    PS_STARTUP,
    PS_NORMAL_ACTIVE,
    PS_NORMAL_PASSIVE,
    PS_HALT,
    PS_MONITOR
  } bcef_proto_state_type;

endpackage

// ---- hdl/bcef_edge_det.sv ----
`timescale 1ns/1ps
`default_nettype none

module bcef_edge_det #(
  parameter int              WIDTH     = 14,
  parameter logic [13:0]     RESET_VAL = 14'h0000
) (
  input  wire logic             clk,     // Controller clock
  input  wire logic             arst_n,  // Async reset, active low
  input  wire logic [WIDTH-1:0] d,       // Levels to watch
  output logic      [WIDTH-1:0] rise     // One-cycle pulse on 0-to-1
);

  logic [WIDTH-1:0] prev_q;

  // Previous value; reset value chosen so no false edge after reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prev_q <= RESET_VAL[WIDTH-1:0];
    end else begin
      prev_q <= d;
    end
  end

  assign rise = d & ~prev_q;

endmodule // bcef_edge_det

`default_nettype wire

// ---- hdl/bcef_flag_bank.sv ----
`timescale 1ns/1ps
`default_nettype none

module bcef_flag_bank #(
  parameter logic [31:0] MASK  = 32'hffff_ffff,
  parameter logic [31:0] RESET = 32'h0000_0000
) (
  input  wire logic        clk,     // Controller clock
  input  wire logic        arst_n,  // Async reset, active low
  input  wire logic [31:0] set,     // Hardware event per bit
  input  wire logic [31:0] sw_clr,  // Software write-1 clear per bit
  input  wire logic [31:0] hw_clr,  // Hardware clear per bit
  output logic      [31:0] flags    // Sticky flag bits
);

  logic [31:0] flags_q;
  logic [31:0] flags_d;

  // Set beats any clear in the same cycle so no event is lost
  assign flags_d = ((flags_q & ~sw_clr & ~hw_clr) | set) & MASK;

  // Sticky storage; unimplemented bits stay zero
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flags_q <= RESET;
    end else begin
      flags_q <= flags_d;
    end
  end

  assign flags = flags_q;

endmodule // bcef_flag_bank

`default_nettype wire

// ---- hdl/bcef_event_flags.sv ----
// Operation
// - Error flags set on event, cleared by writing one (bits 7 and 6 also by hardware); reset clears all.
// - Slot-boundary crossing on channel B or A sets bit 26 or 18.
// - Failed latest transmission on channel B or A sets bit 25 or 17.
// - Rising channel status error bits set channel error flag 24 or 16.
// - Any handler failure flag rising sets handler constraint flag, bit 11.
// - Output transfer request while output buffer busy sets bit 10.
// - Outside config, key-slot buffer 0 header or FIFO buffer change sets bit 9.
// - Outside config, security field locks static or all headers; change sets bit 9.
// - Input buffer register write while host-side busy sets bit 9.
// - Queue-to-output transfer request with empty receive queue sets bit 8.
// - Receive queue overrun sets bit 7; a queue read clears it.
// - RAM parity error sets bit 6; handler parity clear clears it.
// - Command colliding with protocol state change: field zeroed, lock and reject set.
// - At cycle end, any clock correction error in that cycle sets bit 4.
// - Previous cycle sync frames above configured maximum sets bit 3.
// - Too few sync frames (one sync node, two other) sets bit 2.
// - Disallowed or locked command: field zeroed and reject flag bit 1 set.
// - Any change of the two-bit error mode sets bit 0.
// - Status flags set on event, cleared only by writing one; reset clears.
// - Status layout: 25, 24, 17, 16, 15 for symbols, wakeups, dynamic start.
// - Test symbol flags update at window end; wakeup only in listed modes.
// - Transfer done or busy reset sets status bits 11 and 10.
`timescale 1ns/1ps
`default_nettype none
`include "bcef_consts.svh"

module bcef_event_flags (
  input  wire logic                          CLK,               // Controller clock, 10 MHz
  input  wire logic                          ARST_N,            // Async reset, active low
  // Host register port
  input  wire logic [7:0]                    REG_ADDR,          // Register byte offset
  input  wire logic                          REG_WR,            // Write strobe
  input  wire logic                          REG_RD,            // Read strobe
  input  wire logic [31:0]                   REG_WDATA,         // Write data
  output logic      [31:0]                   REG_RDATA,         // Read data, one cycle later
  output logic                               REG_RVALID,        // Read data valid pulse
  // Protocol engine
  input  wire bcef_pkg::bcef_proto_state_type PROTO_STATE,      // Current protocol state
  input  wire logic                          PROTO_STATE_CHG,   // Engine-driven state change
  input  wire logic [1:0]                    ERROR_MODE,        // Protocol error mode field
  input  wire logic                          SLOT_OVERRUN_A,    // Slot boundary crossed, ch A
  input  wire logic                          SLOT_OVERRUN_B,    // Slot boundary crossed, ch B
  input  wire logic                          TX_FAIL_A,         // Latest transmission failed, A
  input  wire logic                          TX_FAIL_B,         // Latest transmission failed, B
  input  wire logic [3:0]                    CH_STATUS_A,       // Syntax/content/bound/bit, A
  input  wire logic [3:0]                    CH_STATUS_B,       // Syntax/content/bound/bit, B
  // Clock synchronisation
  input  wire logic                          CYCLE_END,         // End of communication cycle
  input  wire logic                          RATE_CORR_ERR,     // Rate correction error
  input  wire logic                          OFFS_CORR_ERR,     // Offset correction error
  input  wire logic                          CORR_LIMIT_ERR,    // Correction limit exceeded
  input  wire logic [4:0]                    SYNC_FRAME_CNT,    // Sync frames, previous cycle
  input  wire logic [3:0]                    MAX_SYNC_FRAMES,   // Configured maximum
  input  wire logic                          SYNC_NODE,         // Node sends sync frames
  // Symbols and segments
  input  wire logic                          SYMBOL_WIN_END,    // Symbol window finished
  input  wire logic                          TEST_SYMBOL_A,     // Test symbol in window, A
  input  wire logic                          TEST_SYMBOL_B,     // Test symbol in window, B
  input  wire logic                          WAKE_PATTERN_A,    // Wakeup pattern received, A
  input  wire logic                          WAKE_PATTERN_B,    // Wakeup pattern received, B
  input  wire logic                          DYN_SEG_START,     // Dynamic segment started
  // Message handler and buffers
  input  wire logic [3:0]                    HANDLER_FAILURE,   // Handler failure flags
  input  wire logic                          RAM_PARITY_ERR,    // Parity error on RAM read
  input  wire logic                          HANDLER_PAR_CLR,   // Handler parity flag cleared
  input  wire logic                          RXQ_OVERRUN,       // Receive queue overrun
  input  wire logic                          RXQ_READ,          // Receive queue read
  input  wire logic                          RXQ_EMPTY,         // Receive queue empty
  input  wire logic                          OB_XFER_REQ,       // Host RAM-to-output request
  input  wire logic                          OB_FROM_QUEUE,     // Request targets receive queue
  input  wire logic                          OUT_BUFFER_BUSY,   // Output buffer busy
  input  wire logic                          OB_XFER_DONE,      // RAM-to-output transfer done
  input  wire logic                          IB_XFER_REQ,       // Host input-to-RAM request
  input  wire logic [6:0]                    IB_BUF_NUM,        // Target message buffer
  input  wire logic                          IB_CHG_HEADER,     // Request changes header
  input  wire logic                          IB_CHG_DATA,       // Request changes data
  input  wire logic                          IB_TARGET_QUEUE,   // Target is in receive queue
  input  wire logic                          IB_REG_WRITE,      // Host writes input buffer reg
  input  wire logic                          IN_BUFFER_HOST_BUSY, // Host-side input busy
  input  wire logic                          IN_BUFFER_BUSY,    // Transfer-side input busy
  input  wire logic                          IB_XFER_DONE,      // Input-to-RAM transfer done
  input  wire logic                          BUF0_KEY_SLOT,     // Buffer 0 sends key slots
  input  wire logic [1:0]                    BUFFER_SECURITY,   // Security field
  input  wire logic [7:0]                    FIRST_DYNAMIC_BUF, // First dynamic buffer
  // Host command interface
  input  wire logic                          CMD_WRITE,         // Host writes command field
  input  wire logic [3:0]                    CMD_DATA,          // Command written
  input  wire logic                          CMD_TAKEN,         // Engine consumed command
  output logic      [3:0]                    HOST_COMMAND,      // Command field
  output logic                               CMD_ISSUE,         // Accepted command pulse
  // Flag views
  output logic      [31:0]                   ERROR_EVENT_FLAGS, // Error flags
  output logic      [31:0]                   STATUS_EVENT_FLAGS // Status flags
);

  // Configuration states block the input buffer content checks
  function automatic logic in_config(input bcef_pkg::bcef_proto_state_type st);
    in_config = (st == bcef_pkg::PS_CONFIG) || (st == bcef_pkg::PS_DEFAULT_CONFIG);
  endfunction

  // Which commands each protocol state accepts
  function automatic logic cmd_allowed(input logic [3:0] cmd,
                                       input bcef_pkg::bcef_proto_state_type st);
    logic ok;
    ok = 1'b0;
    case (st)
      bcef_pkg::PS_DEFAULT_CONFIG: ok = (cmd == `BCEF_CMD_CONFIG);
      bcef_pkg::PS_CONFIG:         ok = (cmd == `BCEF_CMD_READY);
      bcef_pkg::PS_READY:          ok = (cmd == `BCEF_CMD_CONFIG) || (cmd == `BCEF_CMD_WAKEUP) ||
                                        (cmd == `BCEF_CMD_RUN);
      bcef_pkg::PS_HALT:           ok = (cmd == `BCEF_CMD_CONFIG);
      default:                     ok = (cmd == `BCEF_CMD_HALT) || (cmd == `BCEF_CMD_FREEZE) ||
                                        (cmd == `BCEF_CMD_READY);
    endcase
    if (cmd == `BCEF_CMD_FREEZE) begin
      ok = 1'b1;
    end
    cmd_allowed = ok;
  endfunction

  // Header or data change through the input buffer that security forbids
  function automatic logic ib_forbidden(input logic [6:0] num,
                                        input logic       hdr,
                                        input logic       dat,
                                        input logic       in_q,
                                        input logic       key0,
                                        input logic [1:0] sec,
                                        input logic [7:0] fdb);
    logic bad;
    bad = 1'b0;
    if (in_q && (hdr || dat)) begin
      bad = 1'b1;
    end
    if (hdr && !in_q) begin
      if (key0 && (num == 7'h00)) begin
        bad = 1'b1;
      end
      if ((sec == `BCEF_SEC_STATIC_LOCK) && ({1'b0, num} < fdb)) begin
        bad = 1'b1;
      end
      if (sec[1]) begin
        bad = 1'b1;
      end
    end
    ib_forbidden = bad;
  endfunction

  logic [31:0] err_flags;
  logic [31:0] stat_flags;
  logic [31:0] err_set;
  logic [31:0] stat_set;
  logic [31:0] err_sw_clr;
  logic [31:0] stat_sw_clr;
  logic [31:0] err_hw_clr;
  logic [13:0] edges;
  logic [1:0]  mode_q;
  logic [2:0]  corr_err_q;
  logic [3:0]  cmd_q;
  logic        issue_q;
  logic [31:0] rdata_q;
  logic        rvalid_q;
  logic        cmd_reject;
  logic        cmd_collide;
  logic        ib_bad;
  logic        cycle_corr_bad;
  logic        wake_mode;
  logic [4:0]  min_sync;

  // Rising edges of channel status, handler failures, and busy releases
  bcef_edge_det #(
    .WIDTH     (14),
    .RESET_VAL (14'h3000)
  ) u_edges (
    .clk    (CLK),
    .arst_n (ARST_N),
    .d      ({~OUT_BUFFER_BUSY, ~IN_BUFFER_BUSY, HANDLER_FAILURE, CH_STATUS_B, CH_STATUS_A}),
    .rise   (edges)
  );

  // Error mode history for change detection
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      mode_q <= 2'h0;
    end else begin
      mode_q <= ERROR_MODE;
    end
  end

  // Clock correction errors accumulated over the running cycle
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      corr_err_q <= 3'h0;
    end else if (CYCLE_END) begin
      corr_err_q <= 3'h0;
    end else begin
      corr_err_q <= corr_err_q | {CORR_LIMIT_ERR, OFFS_CORR_ERR, RATE_CORR_ERR};
    end
  end

  // Errors arriving on the cycle-end edge still count for that cycle
  assign cycle_corr_bad = CYCLE_END &&
                          ((|corr_err_q) || RATE_CORR_ERR || OFFS_CORR_ERR || CORR_LIMIT_ERR);

  // Sync node needs one sync frame, others need two
  assign min_sync = SYNC_NODE ? `BCEF_MIN_SYNC_SYNCNODE : `BCEF_MIN_SYNC_OTHER;

  // Command checks; a locked command interface rejects every write
  assign cmd_reject  = CMD_WRITE &&
                       (err_flags[`BCEF_E_CMD_LOCK] || !cmd_allowed(CMD_DATA, PROTO_STATE));
  assign cmd_collide = CMD_WRITE && !cmd_reject && PROTO_STATE_CHG;

  // Illegal input buffer use, either by content or by timing
  assign ib_bad = (IB_XFER_REQ && !in_config(PROTO_STATE) &&
                   ib_forbidden(IB_BUF_NUM, IB_CHG_HEADER, IB_CHG_DATA, IB_TARGET_QUEUE,
                                BUF0_KEY_SLOT, BUFFER_SECURITY, FIRST_DYNAMIC_BUF))
                || (IB_REG_WRITE && IN_BUFFER_HOST_BUSY);

  // Wakeup patterns only count in these listed modes
  assign wake_mode = (PROTO_STATE == bcef_pkg::PS_WAKEUP)  ||
                     (PROTO_STATE == bcef_pkg::PS_READY)   ||
                     (PROTO_STATE == bcef_pkg::PS_STARTUP) ||
                     (PROTO_STATE == bcef_pkg::PS_MONITOR);

  // Error event set vector
  always_comb begin
    err_set = 32'h0000_0000;
    err_set[`BCEF_E_SLOT_OVR_B] = SLOT_OVERRUN_B;
    err_set[`BCEF_E_SLOT_OVR_A] = SLOT_OVERRUN_A;
    err_set[`BCEF_E_TX_VIOL_B]  = TX_FAIL_B;
    err_set[`BCEF_E_TX_VIOL_A]  = TX_FAIL_A;
    err_set[`BCEF_E_CH_ERR_B]   = |edges[7:4];
    err_set[`BCEF_E_CH_ERR_A]   = |edges[3:0];
    err_set[`BCEF_E_HANDLER]    = |edges[11:8];
    err_set[`BCEF_E_BAD_OB]     = OB_XFER_REQ && OUT_BUFFER_BUSY;
    err_set[`BCEF_E_BAD_IB]     = ib_bad;
    err_set[`BCEF_E_EMPTY_Q]    = OB_XFER_REQ && OB_FROM_QUEUE && RXQ_EMPTY;
    err_set[`BCEF_E_RXQ_OVR]    = RXQ_OVERRUN;
    err_set[`BCEF_E_PARITY]     = RAM_PARITY_ERR;
    err_set[`BCEF_E_CMD_LOCK]   = cmd_collide;
    err_set[`BCEF_E_CLK_CORR]   = cycle_corr_bad;
    err_set[`BCEF_E_SYNC_OVF]   = CYCLE_END &&
                                  (SYNC_FRAME_CNT > {1'b0, MAX_SYNC_FRAMES});
    err_set[`BCEF_E_SYNC_UNF]   = CYCLE_END && (SYNC_FRAME_CNT < min_sync);
    err_set[`BCEF_E_CMD_REJ]    = cmd_reject || cmd_collide;
    err_set[`BCEF_E_MODE_CHG]   = (ERROR_MODE != mode_q);
  end

  // Hardware clears: queue read and handler parity clear
  always_comb begin
    err_hw_clr = 32'h0000_0000;
    err_hw_clr[`BCEF_E_RXQ_OVR] = RXQ_READ;
    err_hw_clr[`BCEF_E_PARITY]  = HANDLER_PAR_CLR;
  end

  // Status event set vector
  always_comb begin
    stat_set = 32'h0000_0000;
    stat_set[`BCEF_S_TEST_SYM_B] = SYMBOL_WIN_END && TEST_SYMBOL_B;
    stat_set[`BCEF_S_TEST_SYM_A] = SYMBOL_WIN_END && TEST_SYMBOL_A;
    stat_set[`BCEF_S_WAKE_B]     = WAKE_PATTERN_B && wake_mode;
    stat_set[`BCEF_S_WAKE_A]     = WAKE_PATTERN_A && wake_mode;
    stat_set[`BCEF_S_DYN_SEG]    = DYN_SEG_START;
    stat_set[`BCEF_S_OUT_DONE]   = OB_XFER_DONE || edges[13];
    stat_set[`BCEF_S_IN_DONE]    = IB_XFER_DONE || edges[12];
  end

  // Write-one-to-clear decode; writing zero leaves a bit alone
  assign err_sw_clr  = (REG_WR && (REG_ADDR == `BCEF_ERR_FLAGS_OFS))  ? REG_WDATA
                                                                      : 32'h0000_0000;
  assign stat_sw_clr = (REG_WR && (REG_ADDR == `BCEF_STAT_FLAGS_OFS)) ? REG_WDATA
                                                                      : 32'h0000_0000;

  // Error flags; set has priority over both clears
  bcef_flag_bank #(
    .MASK  (`BCEF_ERR_FLAGS_MASK),
    .RESET (`BCEF_ERR_FLAGS_RST)
  ) u_err_flags (
    .clk    (CLK),
    .arst_n (ARST_N),
    .set    (err_set),
    .sw_clr (err_sw_clr),
    .hw_clr (err_hw_clr),
    .flags  (err_flags)
  );

  // Status flags; no hardware clear source
  bcef_flag_bank #(
    .MASK  (`BCEF_STAT_FLAGS_MASK),
    .RESET (`BCEF_STAT_FLAGS_RST)
  ) u_stat_flags (
    .clk    (CLK),
    .arst_n (ARST_N),
    .set    (stat_set),
    .sw_clr (stat_sw_clr),
    .hw_clr (32'h0000_0000),
    .flags  (stat_flags)
  );

  // Command field: rejected or colliding commands leave it at zero
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cmd_q <= `BCEF_CMD_NONE;
    end else if (cmd_reject || cmd_collide) begin
      cmd_q <= `BCEF_CMD_NONE;
    end else if (CMD_WRITE) begin
      cmd_q <= CMD_DATA;
    end else if (CMD_TAKEN) begin
      cmd_q <= `BCEF_CMD_NONE;
    end
  end

  // Accepted command handed to the protocol engine
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      issue_q <= 1'b0;
    end else begin
      issue_q <= CMD_WRITE && !cmd_reject && !cmd_collide;
    end
  end

  // Registered read port; unmapped offsets read as zero
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rdata_q  <= 32'h0000_0000;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= REG_RD;
      if (REG_RD) begin
        case (REG_ADDR)
          `BCEF_ERR_FLAGS_OFS:  rdata_q <= err_flags;
          `BCEF_STAT_FLAGS_OFS: rdata_q <= stat_flags;
          default:              rdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign REG_RDATA          = rdata_q;
  assign REG_RVALID         = rvalid_q;
  assign HOST_COMMAND       = cmd_q;
  assign CMD_ISSUE          = issue_q;
  assign ERROR_EVENT_FLAGS  = err_flags;
  assign STATUS_EVENT_FLAGS = stat_flags;

endmodule // bcef_event_flags

`default_nettype wire

// ---- dv/bcef_event_flags_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module bcef_event_flags_props (
  input wire logic        CLK, ARST_N, REG_WR,    // Clock, reset, write
  input wire logic [7:0]  REG_ADDR,               // Offset
  input wire logic [31:0] REG_WDATA, ERROR_EVENT_FLAGS, STATUS_EVENT_FLAGS, // Data, flags
  input wire logic        SLOT_OVERRUN_A, SLOT_OVERRUN_B, TX_FAIL_A, // Channel events
  input wire logic        RXQ_READ, RXQ_OVERRUN, RAM_PARITY_ERR, DYN_SEG_START, WAKE_PATTERN_A,
  input wire logic [1:0]  ERROR_MODE,             // Error mode
  input wire bcef_pkg::bcef_proto_state_type PROTO_STATE // State
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  // Host write aimed at the error flags
  wire clr_e = REG_WR && REG_ADDR == 8'h00;
  a_slot_a_sets: assert property (SLOT_OVERRUN_A |=> ERROR_EVENT_FLAGS[18])
    else $error("slot flag A not set");
  a_tx_fail_sets: assert property (TX_FAIL_A |=> ERROR_EVENT_FLAGS[17])
    else $error("tx flag A not set");
  a_flag_holds: assert property (ERROR_EVENT_FLAGS[18] && !(clr_e && REG_WDATA[18])
    |=> ERROR_EVENT_FLAGS[18]) else $error("flag lost");
  a_w1c_clears: assert property (clr_e && REG_WDATA[18] && !SLOT_OVERRUN_A
    |=> !ERROR_EVENT_FLAGS[18]) else $error("clear ignored");
  a_set_wins: assert property (clr_e && REG_WDATA[26] && SLOT_OVERRUN_B
    |=> ERROR_EVENT_FLAGS[26]) else $error("set lost to clear");
  a_queue_read_clr: assert property (RXQ_READ && !RXQ_OVERRUN
    |=> !ERROR_EVENT_FLAGS[7]) else $error("overrun not cleared");
  a_parity_sets: assert property (RAM_PARITY_ERR |=> ERROR_EVENT_FLAGS[6])
    else $error("parity flag not set");
  a_mode_change: assert property ($changed(ERROR_MODE) |=> ERROR_EVENT_FLAGS[0])
    else $error("mode change missed");
  a_dyn_seg_sets: assert property (DYN_SEG_START |=> STATUS_EVENT_FLAGS[15])
    else $error("segment flag not set");
  a_wake_gated: assert property (WAKE_PATTERN_A && !STATUS_EVENT_FLAGS[16] &&
    PROTO_STATE == bcef_pkg::PS_NORMAL_ACTIVE |=> !STATUS_EVENT_FLAGS[16]) else $error("wake");
  cover property (clr_e && REG_WDATA[26] && SLOT_OVERRUN_B);
  cover property (RXQ_READ && ERROR_EVENT_FLAGS[7]);
  cover property ($changed(ERROR_MODE));
endmodule // bcef_event_flags_props
bind bcef_event_flags bcef_event_flags_props u_bcef_event_flags_props (.*);
`default_nettype wire

// ---- dv/bcef_event_flags_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module bcef_event_flags_tb;
  `define CHK(a, e, m) begin comparisons++; if ((a) !== (e)) begin n_errors++; $display("FAIL %0t %s", $time, m); end end
  logic CLK = 0, ARST_N = 0, REG_WR = 0, REG_RD = 0, PROTO_STATE_CHG = 0, SLOT_OVERRUN_A = 0;
  logic SLOT_OVERRUN_B = 0, TX_FAIL_A = 0, TX_FAIL_B = 0, CYCLE_END = 0, RATE_CORR_ERR = 0;
  logic OFFS_CORR_ERR = 0, CORR_LIMIT_ERR = 0, SYNC_NODE = 1, SYMBOL_WIN_END = 0, TEST_SYMBOL_A = 0;
  logic TEST_SYMBOL_B = 0, WAKE_PATTERN_A = 0, WAKE_PATTERN_B = 0, DYN_SEG_START = 0;
  logic RAM_PARITY_ERR = 0, HANDLER_PAR_CLR = 0, RXQ_OVERRUN = 0, RXQ_READ = 0, RXQ_EMPTY = 1;
  logic OB_XFER_REQ = 0, OB_FROM_QUEUE = 0, OUT_BUFFER_BUSY = 0, OB_XFER_DONE = 0, IB_XFER_REQ = 0;
  logic IB_CHG_HEADER = 0, IB_CHG_DATA = 0, IB_TARGET_QUEUE = 0, IB_REG_WRITE = 0, CMD_TAKEN = 0;
  logic IN_BUFFER_HOST_BUSY = 0, IN_BUFFER_BUSY = 0, IB_XFER_DONE = 0, BUF0_KEY_SLOT = 0;
  logic CMD_WRITE = 0, REG_RVALID, CMD_ISSUE;
  logic [1:0] ERROR_MODE = 2'h0, BUFFER_SECURITY = 2'h0;
  logic [3:0] CH_STATUS_A = 4'h0, CH_STATUS_B = 4'h0, MAX_SYNC_FRAMES = 4'h4;
  logic [3:0] HANDLER_FAILURE = 4'h0, CMD_DATA = 4'h0, HOST_COMMAND;
  logic [4:0] SYNC_FRAME_CNT = 5'h02;
  logic [6:0] IB_BUF_NUM = 7'h00;
  logic [7:0] REG_ADDR = 8'h00, FIRST_DYNAMIC_BUF = 8'h00;
  logic [31:0] REG_WDATA = 32'h0, REG_RDATA, ERROR_EVENT_FLAGS, STATUS_EVENT_FLAGS;
  bcef_pkg::bcef_proto_state_type PROTO_STATE = bcef_pkg::PS_DEFAULT_CONFIG;
  int n_errors = 0, comparisons = 0, cyc = 0;
  bcef_event_flags u_bcef_event_flags (.*);
  // Clock and hang guard; the run needs well under 1000 cycles
  always #50 CLK = ~CLK;
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      summarize();
    end
  end
  // One-cycle event pulse, driven off the sampling edge
  task automatic pulse(ref logic s);
    @(negedge CLK) s = 1;
    @(negedge CLK) s = 0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge CLK) begin REG_ADDR = a; REG_WDATA = d; REG_WR = 1; end
    @(negedge CLK) REG_WR = 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(negedge CLK) begin REG_ADDR = a; REG_RD = 1; end
    @(negedge CLK) REG_RD = 0;
    `CHK({REG_RVALID, REG_RDATA}, {1'b1, e}, "read")
  endtask
  // Command write; checks field, issue pulse, lock and reject flags
  task automatic cmd(input logic [3:0] c, input logic chg, input logic [6:0] e);
    @(negedge CLK) begin CMD_DATA = c; CMD_WRITE = 1; PROTO_STATE_CHG = chg; end
    @(negedge CLK) begin CMD_WRITE = 0; PROTO_STATE_CHG = 0; end
    `CHK({HOST_COMMAND, CMD_ISSUE, ERROR_EVENT_FLAGS[5], ERROR_EVENT_FLAGS[1]}, e, "command")
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge CLK);
    ARST_N = 1;
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    pulse(SLOT_OVERRUN_A);
    wr(8'h00, 32'h0);
    rd(8'h00, 32'h0004_0000);
    wr(8'h00, 32'h0004_0000);
    rd(8'h00, 32'h0);
    @(negedge CLK) begin SLOT_OVERRUN_B = 1; REG_WDATA = 32'h0400_0000; REG_WR = 1; end
    @(negedge CLK) begin SLOT_OVERRUN_B = 0; REG_WR = 0; end
    `CHK(ERROR_EVENT_FLAGS, 32'h0400_0000, "set vs clear")
    $display("test write-one-clear done");
    CH_STATUS_B = 4'h1;
    @(negedge CLK) begin CH_STATUS_A = 4'h8; HANDLER_FAILURE = 4'h1; ERROR_MODE = 2'h1; end
    pulse(TX_FAIL_A);
    pulse(TX_FAIL_B);
    pulse(RAM_PARITY_ERR);
    pulse(RXQ_OVERRUN);
    `CHK(ERROR_EVENT_FLAGS, 32'h0703_08c1, "events")
    pulse(RXQ_READ);
    pulse(HANDLER_PAR_CLR);
    `CHK(ERROR_EVENT_FLAGS, 32'h0703_0801, "hw clears")
    wr(8'h00, 32'hffff_ffff);
    cmd(4'h4, 1'b0, 7'h01);
    cmd(4'h1, 1'b0, 7'h0d);
    cmd(4'h1, 1'b1, 7'h03);
    cmd(4'h1, 1'b0, 7'h03);
    $display("test events and commands done");
    PROTO_STATE = bcef_pkg::PS_NORMAL_ACTIVE;
    pulse(WAKE_PATTERN_A);
    `CHK(STATUS_EVENT_FLAGS, 32'h0, "wake gate")
    PROTO_STATE = bcef_pkg::PS_READY;
    TEST_SYMBOL_A = 1;
    TEST_SYMBOL_B = 1;
    pulse(WAKE_PATTERN_A);
    pulse(WAKE_PATTERN_B);
    pulse(DYN_SEG_START);
    pulse(SYMBOL_WIN_END);
    pulse(IN_BUFFER_BUSY);
    pulse(OB_XFER_DONE);
    rd(8'h04, 32'h0303_8c00);
    wr(8'h00, 32'hffff_ffff);
    SYNC_FRAME_CNT = 5'h05;
    RATE_CORR_ERR = 1;
    pulse(CYCLE_END);
    `CHK(ERROR_EVENT_FLAGS, 32'h18, "sync high")
    RATE_CORR_ERR = 0;
    SYNC_FRAME_CNT = 5'h01;
    SYNC_NODE = 0;
    pulse(CYCLE_END);
    `CHK(ERROR_EVENT_FLAGS, 32'h1c, "sync low")
    OUT_BUFFER_BUSY = 1;
    OB_FROM_QUEUE = 1;
    IB_TARGET_QUEUE = 1;
    IB_CHG_DATA = 1;
    pulse(OB_XFER_REQ);
    pulse(IB_XFER_REQ);
    `CHK(ERROR_EVENT_FLAGS, 32'h71c, "buffers")
    PROTO_STATE = bcef_pkg::PS_NORMAL_ACTIVE;
    wr(8'h00, 32'hffff_ffff);
    IB_TARGET_QUEUE = 0;
    IB_CHG_HEADER = 1;
    BUFFER_SECURITY = 2'h1;
    FIRST_DYNAMIC_BUF = 8'h02;
    IB_BUF_NUM = 7'h01;
    PROTO_STATE = bcef_pkg::PS_CONFIG;
    pulse(IB_XFER_REQ);
    `CHK(ERROR_EVENT_FLAGS, 32'h0, "config gate")
    PROTO_STATE = bcef_pkg::PS_NORMAL_ACTIVE;
    pulse(IB_XFER_REQ);
    `CHK(ERROR_EVENT_FLAGS, 32'h200, "static lock")
    wr(8'h00, 32'h200);
    pulse(IB_REG_WRITE);
    `CHK(ERROR_EVENT_FLAGS, 32'h0, "idle write")
    IN_BUFFER_HOST_BUSY = 1;
    pulse(IB_REG_WRITE);
    `CHK(ERROR_EVENT_FLAGS, 32'h200, "busy write")
    // Quiet the level inputs so release shows no fresh edges
    HANDLER_FAILURE = 4'h0;
    ERROR_MODE = 2'h0;
    @(negedge CLK) begin ARST_N = 0; CH_STATUS_A = 4'h0; CH_STATUS_B = 4'h0; end
    @(negedge CLK) ARST_N = 1;
    @(negedge CLK);
    `CHK({ERROR_EVENT_FLAGS, STATUS_EVENT_FLAGS}, 64'h0, "reset")
    $display("test sync, buffers and reset done");
    summarize();
  end
endmodule // bcef_event_flags_tb
`default_nettype wire
